// ===== core/txsc_alert.sv
// alert unit: pending flags, interrupt level and log push for the subaddress
`timescale 1ns/10ps
module txsc_alert
    import txsc_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   ce,
    txsc_alert_if.alert ev,
    input  wire logic   alert_ack,
    output logic        pend_index_zero,
    output logic        pend_access,
    output logic        interrupt_out,
    output logic        log_push,
    output logic [1:0]  log_code
);

    txsc_alert_s s_q;
    txsc_alert_s s_d;

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    // ack clears first so a same-cycle event still lands
    always_comb begin
        s_d          = s_q;
        s_d.log_push = 1'b0;
        if (alert_ack) begin
            s_d.pend_ixz = 1'b0;
            s_d.pend_acc = 1'b0;
            s_d.int_lvl  = 1'b0;
        end
        if (ev.ixz_ev) begin
            s_d.pend_ixz = 1'b1;                 // [RQ10]
            s_d.int_lvl  = 1'b1;
        end
        if (ev.acc_ev) begin
            s_d.pend_acc = 1'b1;                 // [RQ11]
            s_d.int_lvl  = 1'b1;
        end
        if (ev.ixz_ev || ev.acc_ev) begin
            s_d.log_push = 1'b1;                 // [RQ10] [RQ11]
            s_d.log_code = {ev.ixz_ev, ev.acc_ev};
        end
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign pend_index_zero = s_q.pend_ixz;
    assign pend_access     = s_q.pend_acc;
    assign interrupt_out   = s_q.int_lvl;
    assign log_push        = s_q.log_push;
    assign log_code        = s_q.log_code;

endmodule : txsc_alert

// ===== core/txsc_core.sv
// control word of one transmit subaddress: host access, device updates, buffer select
`timescale 1ns/10ps
`include "txsc_regs.svh"
module txsc_core
    import txsc_pkg::*;
#(
    parameter logic [4:0] SUBADDR = 5'h01
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        software_reset,
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    input  wire logic [15:0] host_wdata,
    output logic      [15:0] host_rdata,
    input  wire logic        terminal_enable_pin,
    input  wire logic        terminal_enable,
    input  wire logic        terminal_execute,
    input  wire logic        pointer_toggle_suppress,
    input  wire logic        global_busy,
    input  wire logic        index_zero_alert_global,
    input  wire logic        access_alert_global,
    input  wire logic        cmd_start,
    input  wire logic        cmd_tr,
    input  wire logic [4:0]  cmd_sa,
    input  wire logic        cmd_broadcast_received_flag,
    input  wire logic        msg_done,
    input  wire logic        msg_error,
    input  wire logic        msg_illegal,
    input  wire logic        count_reached_zero,
    input  wire logic        alert_ack,
    output logic             busy_reply,
    output logic             transmit_data_enable,
    output logic             use_pointer_b,
    output logic [1:0]       buffer_mode,
    output logic             pingpong_acknowledge,
    output logic             interrupt_out,
    output logic             pend_index_zero,
    output logic             pend_access,
    output logic             log_push,
    output logic [1:0]       log_code
);

    // -------------------------------------------------------------
    // elaboration check
    // -------------------------------------------------------------
    if (SUBADDR < `TXSC_SA_MIN || SUBADDR > `TXSC_SA_MAX) begin : g_bad_sa
        $error("transmit subaddress out of range");
    end

    txsc_core_s   s_q;
    txsc_core_s   s_d;
    txsc_mode_e   mode;
    logic         sa_ok;
    logic         applies;
    logic         done_ok;
    logic         toggle;
    logic [15:0]  wmask;
    txsc_alert_if aif ();

    // -------------------------------------------------------------
    // command qualification and decode
    // -------------------------------------------------------------
    // only transmit commands inside 1..30 aimed at this subaddress
    assign sa_ok   = cmd_sa >= `TXSC_SA_MIN && cmd_sa <= `TXSC_SA_MAX;       // [RQ1]
    assign applies = cmd_start && cmd_tr && sa_ok && cmd_sa == SUBADDR;      // [RQ1]
    assign mode    = txsc_decode_mode(s_q.word[2:0]);                         // [RQ20]
    assign done_ok = msg_done && s_q.in_msg;

    // writable bits depend on whether the terminal is executing
    assign wmask = terminal_execute ? `TXSC_WR_ANYTIME
                                    : (`TXSC_WR_ANYTIME | `TXSC_WR_IDLE);    // [RQ4] [RQ5]

    // pointer flips only on a clean ping-pong message that sent data
    assign toggle = done_ok && terminal_execute && mode == TXSC_MODE_PINGPONG
                    && s_q.word[`TXSC_BIT_ACK]                               // [RQ22]
                    && !msg_error                                            // [RQ16]
                    && !s_q.busy                                             // [RQ13]
                    && !(msg_illegal && pointer_toggle_suppress);            // [RQ17]

    // completion events for the alert unit
    assign aif.acc_ev = done_ok && s_q.word[`TXSC_BIT_ACCESS]
                        && access_alert_global;                               // [RQ11]
    assign aif.ixz_ev = done_ok && s_q.word[`TXSC_BIT_IXZERO]
                        && index_zero_alert_global && count_reached_zero;     // [RQ9]

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        s_d          = s_q;
        s_d.pin_meta = terminal_enable_pin;
        s_d.pin_sync = s_q.pin_meta;

        // host write through the mask; device bits never reach it
        if (host_wr) begin
            s_d.word = (s_q.word & ~wmask) | (host_wdata & wmask);           // [RQ4] [RQ5]
            if (wmask[`TXSC_BIT_PINGPONG_ENABLE]) begin
                s_d.armed = s_q.pin_sync && terminal_enable;                  // [RQ3]
            end
        end

        // read returns the word as it stands, then clears activity
        if (host_rd) begin
            s_d.rdata               = s_q.word;
            s_d.word[`TXSC_BIT_ACT] = 1'b0;                                   // [RQ8]
        end

        // acknowledge handshake, device side, only while executing
        if (terminal_execute) begin
            if (!s_d.word[`TXSC_BIT_PINGPONG_ENABLE] || s_d.word[`TXSC_BIT_PAUSE]) begin
                s_d.word[`TXSC_BIT_ACK] = 1'b0;                               // [RQ21]
            end else if (s_q.armed) begin
                s_d.word[`TXSC_BIT_ACK] = 1'b1;                               // [RQ21] [RQ3]
            end
        end

        // command start: latch busy answer and buffer choice
        if (applies) begin
            s_d.in_msg  = 1'b1;
            s_d.busy    = s_q.word[`TXSC_BIT_BUSY] || global_busy;           // [RQ12]
            s_d.data_en = !(s_q.word[`TXSC_BIT_BUSY] || global_busy);        // [RQ13]
            s_d.use_b   = mode == TXSC_MODE_PINGPONG
                          && s_q.word[`TXSC_BIT_BUFSEL];                      // [RQ15] [RQ19]
            if (cmd_broadcast_received_flag && terminal_execute) begin
                s_d.word[`TXSC_BIT_BROADCAST_RECEIVED_FLAG] = 1'b1;
            end
        end

        // completion: activity set wins over a same-cycle read clear
        if (done_ok) begin
            s_d.in_msg  = 1'b0;
            s_d.busy    = 1'b0;
            s_d.data_en = 1'b0;
            if (terminal_execute) begin
                s_d.word[`TXSC_BIT_ACT] = 1'b1;                               // [RQ14]
            end
            if (toggle) begin
                s_d.word[`TXSC_BIT_BUFSEL] = !s_q.word[`TXSC_BIT_BUFSEL];   // [RQ16]
            end
        end

        // software reset clears three status bits and the message state
        if (software_reset) begin
            s_d.word   = s_d.word & ~`TXSC_SR_CLEAR;                          // [RQ7] [RQ18]
            s_d.in_msg = 1'b0;
            s_d.busy   = 1'b0;
            s_d.data_en = 1'b0;
            s_d.use_b  = 1'b0;
        end

        // bit 13 is not used and always reads zero
        s_d.word[13] = 1'b0;
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    // master reset is the async reset: whole word goes to zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q      <= '0;
            s_q.word <= `TXSC_RESET_VAL;                                      // [RQ6] [RQ18]
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign host_rdata           = s_q.rdata;
    assign busy_reply           = s_q.busy;
    assign transmit_data_enable = s_q.data_en;
    assign use_pointer_b        = s_q.use_b;
    assign buffer_mode          = mode;
    assign pingpong_acknowledge = s_q.word[`TXSC_BIT_ACK];

    // -------------------------------------------------------------
    // alert unit
    // -------------------------------------------------------------
    txsc_alert u_alert (
        .clk             (clk),
        .rst             (rst),
        .ce              (ce),
        .ev              (aif.alert),
        .alert_ack       (alert_ack),
        .pend_index_zero (pend_index_zero),
        .pend_access     (pend_access),
        .interrupt_out   (interrupt_out),
        .log_push        (log_push),
        .log_code        (log_code)
    );

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence seq_clean_done;
        ce && toggle && !software_reset;
    endsequence

    sequence seq_quiet;
        !software_reset && !applies && !done_ok && !host_rd;
    endsequence

    chk_sa_range_gate: assert property (                                     // [RQ1]
        ce && cmd_start && !sa_ok && !s_q.in_msg |=> !s_q.in_msg)
        else $error("out of range subaddress opened a message");

    chk_device_bits_wr: assert property (                                    // [RQ4]
        (ce && host_wr && !terminal_execute) and seq_quiet
        |=> s_q.word[11:8] == $past(s_q.word[11:8]))
        else $error("host write changed device bits");

    chk_idle_bits_wr: assert property (                                      // [RQ5]
        ce && host_wr && terminal_execute && !software_reset
        |=> s_q.word[7:4] == $past(s_q.word[7:4]) && s_q.word[2:0] == $past(s_q.word[2:0]))
        else $error("idle-only bits written while executing");

    chk_swreset_bits: assert property (                                      // [RQ7]
        ce && software_reset && !host_wr
        |=> s_q.word[11:9] == 3'h0 && s_q.word[15:12] == $past(s_q.word[15:12]))
        else $error("software reset cleared the wrong bits");

    chk_read_clears: assert property (                                       // [RQ8]
        ce && host_rd && !done_ok |=> !s_q.word[`TXSC_BIT_ACT] ##0 host_rdata == $past(s_q.word))
        else $error("read did not clear activity");

    chk_activity_set: assert property (                                      // [RQ14]
        ce && done_ok && terminal_execute && !software_reset |=> s_q.word[`TXSC_BIT_ACT])
        else $error("completion did not set activity");

    chk_force_busy: assert property (                                        // [RQ12]
        ce && applies && s_q.word[`TXSC_BIT_BUSY] && !software_reset
        |=> busy_reply && !transmit_data_enable)
        else $error("forced busy not answered");

    chk_busy_no_data: assert property (                                      // [RQ13]
        busy_reply |-> !transmit_data_enable)
        else $error("data sent while busy");

    chk_pointer_flip: assert property (                                      // [RQ16]
        seq_clean_done |=> s_q.word[`TXSC_BIT_BUFSEL] != $past(s_q.word[`TXSC_BIT_BUFSEL]))
        else $error("buffer select did not flip");

    chk_unacked_hold: assert property (                                      // [RQ22]
        ce && !s_q.word[`TXSC_BIT_ACK] && !software_reset
        |=> s_q.word[`TXSC_BIT_BUFSEL] == $past(s_q.word[`TXSC_BIT_BUFSEL]))
        else $error("pointer moved without acknowledge");

    chk_access_alert: assert property (                                      // [RQ11]
        ce && aif.acc_ev |=> interrupt_out && pend_access && log_push)
        else $error("access alert not raised");

    chk_ixz_alert: assert property (                                         // [RQ10]
        ce && aif.ixz_ev |=> interrupt_out && pend_index_zero && log_push && log_code[1])
        else $error("index zero alert not raised");

endmodule : txsc_core

// ===== pkg/txsc_alert_if.sv
// completion events passed from the control word core to its alert unit
`timescale 1ns/10ps
interface txsc_alert_if;
    logic ixz_ev;
    logic acc_ev;

    modport core  (output ixz_ev, output acc_ev);
    modport alert (input ixz_ev, input acc_ev);
endinterface : txsc_alert_if

// ===== pkg/txsc_pkg.sv
// types shared by the transmit subaddress control word logic
package txsc_pkg;

    // buffer modes of one subaddress
    typedef enum logic [1:0] {
        TXSC_MODE_INDEXED  = 2'b00,
        TXSC_MODE_CIRC1    = 2'b01,
        TXSC_MODE_CIRC2    = 2'b10,
        TXSC_MODE_PINGPONG = 2'b11
    } txsc_mode_e;

    // whole state of the control word core
    typedef struct packed {
        logic [15:0] word;
        logic [15:0] rdata;
        logic        armed;
        logic        in_msg;
        logic        busy;
        logic        data_en;
        logic        use_b;
        logic        pin_meta;
        logic        pin_sync;
    } txsc_core_s;

    // whole state of the alert unit
    typedef struct packed {
        logic       pend_ixz;
        logic       pend_acc;
        logic       int_lvl;
        logic       log_push;
        logic [1:0] log_code;
    } txsc_alert_s;

    // priority decode of the three mode enables, low bits of the word
    function automatic txsc_mode_e txsc_decode_mode(input logic [2:0] en);
        if (en[2]) begin
            return TXSC_MODE_PINGPONG;
        end else if (en[1]) begin
            return TXSC_MODE_CIRC2;
        end else if (en[0]) begin
            return TXSC_MODE_CIRC1;
        end
        return TXSC_MODE_INDEXED;
    endfunction : txsc_decode_mode

endpackage : txsc_pkg

// ===== pkg/txsc_regs.svh
// field layout, masks and reset values of the transmit subaddress control word
//
// Summary of operation
// [RQ1] word applies only to valid transmit commands with subaddress 1 to 30
// [RQ2] host writes ping-pong words only while both terminal enables are set
// [RQ3] write without both enables blocks automatic acknowledge; buffer stays the same
// [RQ4] bits 8 to 11 ignore host writes; device updates them only while executing
// [RQ5] bits 0-2 and 4-7 writable only when idle; bits 3, 12, 14, 15 always
// [RQ6] master reset clears the whole word to zero
// [RQ7] software reset clears only activity, buffer select and broadcast bits
// [RQ8] any host read of the word clears the activity flag afterwards; a completion in the same cycle while executing leaves it set
// [RQ9] bit 15 with global enable alerts when the message countdown reaches zero
// [RQ10] index-zero alert posts pending entry, raises interrupt pin and logs it
// [RQ11] bit 14 with global enable alerts after every valid transmit command
// [RQ12] bit 12 forces a busy reply for this subaddress regardless of global busy
// [RQ13] busy reply sends no data words and never toggles the buffer select
// [RQ14] activity flag set when a message to this subaddress completes
// [RQ15] in ping-pong, buffer select zero picks pointer A, one picks pointer B
// [RQ16] in ping-pong, buffer select inverts after every error-free message
// [RQ17] host sets toggle suppression to hold the pointer after illegal or busy messages
// [RQ18] buffer select reads zero after master or software reset
// [RQ19] buffer select has no effect in indexed or circular modes
// [RQ20] mode priority: ping-pong, then circular two, then circular one, else indexed
// [RQ21] pause request clears the acknowledge; releasing it sets the acknowledge again
// [RQ22] ping-pong enabled but unacknowledged: same buffer every message, no toggle
`ifndef TXSC_REGS_SVH
`define TXSC_REGS_SVH

`define TXSC_RESET_VAL    16'h0000
`define TXSC_BIT_CIR1     0
`define TXSC_BIT_CIR2     1
`define TXSC_BIT_PINGPONG_ENABLE     2
`define TXSC_BIT_PAUSE    3
`define TXSC_BIT_ACK      8
`define TXSC_BIT_BROADCAST_RECEIVED_FLAG    9
`define TXSC_BIT_BUFSEL   10
`define TXSC_BIT_ACT      11
`define TXSC_BIT_BUSY     12
`define TXSC_BIT_ACCESS   14
`define TXSC_BIT_IXZERO   15
`define TXSC_WR_ANYTIME   16'hd008
`define TXSC_WR_IDLE      16'h00f7
`define TXSC_SR_CLEAR     16'h0e00
`define TXSC_SA_MIN       5'h01
`define TXSC_SA_MAX       5'h1e

`endif

// ===== verification/txsc_bc_model.sv
// bus controller model: issues commands to the terminal and completes messages
`timescale 1ns/10ps
module txsc_bc_model (
    input  wire logic       clk,
    output logic            cmd_start,
    output logic            cmd_tr,
    output logic [4:0]      cmd_sa,
    output logic            cmd_broadcast_received_flag,
    output logic            msg_done,
    output logic            msg_error,
    output logic            msg_illegal,
    output logic            count_reached_zero
);
    // ---------------------------------------------------------------
    // idle state of the command side
    // ---------------------------------------------------------------
    initial begin
        cmd_start          = 1'b0;
        cmd_tr             = 1'b0;
        cmd_sa             = 5'h00;
        cmd_broadcast_received_flag          = 1'b0;
        msg_done           = 1'b0;
        msg_error          = 1'b0;
        msg_illegal        = 1'b0;
        count_reached_zero = 1'b0;
    end

    // one command strobe; qualifiers flip afterwards so stale values never look valid
    task automatic start(input logic tr, input logic [4:0] sa, input logic broadcast_received_flag);
        @(negedge clk);
        cmd_start = 1'b1;
        cmd_tr    = tr;
        cmd_sa    = sa;
        cmd_broadcast_received_flag = broadcast_received_flag;
        @(negedge clk);
        cmd_start = 1'b0;
        cmd_tr    = ~tr;
        cmd_sa    = ~sa;
        cmd_broadcast_received_flag = ~broadcast_received_flag;
    endtask : start

    // message completion after a gap, prompt (gap 0) or slow
    task automatic finish(input logic err, input logic ill, input logic zero, input int gap);
        repeat (gap) @(negedge clk);
        msg_done           = 1'b1;
        msg_error          = err;
        msg_illegal        = ill;
        count_reached_zero = zero;
        @(negedge clk);
        msg_done           = 1'b0;
        msg_error          = ~err;
        msg_illegal        = ~ill;
        count_reached_zero = ~zero;
    endtask : finish
endmodule : txsc_bc_model

// ===== verification/txsc_core_bench.sv
// self-checking bench of the transmit subaddress control word core
`timescale 1ns/10ps
`define TXSC_CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module txsc_core_bench;
    import txsc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, software_reset = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
    logic [15:0] host_wdata = 16'h0000;
    logic [15:0] host_rdata;
    logic pin = 1'b1, ten = 1'b1, execute = 1'b0, suppress = 1'b0, gbusy = 1'b0;
    logic gixz = 1'b0, gacc = 1'b0, alert_ack = 1'b0, ce = 1'b1;
    logic cmd_start, cmd_tr, cmd_broadcast_received_flag, msg_done, msg_error, msg_illegal, czero;
    logic [4:0] cmd_sa;
    logic busy_reply, transmit_data_enable, use_pointer_b, pingpong_acknowledge;
    logic interrupt_out, pend_index_zero, pend_access, log_push;
    logic [1:0] buffer_mode, log_code;
    int n_errors = 0, tests_run = 0;

    // ---------------------------------------------------------------
    // clock, design and partner
    // ---------------------------------------------------------------
    initial begin
        forever #12.5 clk = ~clk;
    end

    txsc_core #(.SUBADDR(5'h01)) uut (.clk(clk), .rst(rst), .ce(ce), .software_reset(software_reset),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .terminal_enable_pin(pin), .terminal_enable(ten), .terminal_execute(execute),
        .pointer_toggle_suppress(suppress), .global_busy(gbusy), .index_zero_alert_global(gixz),
        .access_alert_global(gacc), .cmd_start(cmd_start), .cmd_tr(cmd_tr), .cmd_sa(cmd_sa),
        .cmd_broadcast_received_flag(cmd_broadcast_received_flag), .msg_done(msg_done), .msg_error(msg_error), .msg_illegal(msg_illegal),
        .count_reached_zero(czero), .alert_ack(alert_ack), .busy_reply(busy_reply),
        .transmit_data_enable(transmit_data_enable), .use_pointer_b(use_pointer_b),
        .buffer_mode(buffer_mode), .pingpong_acknowledge(pingpong_acknowledge),
        .interrupt_out(interrupt_out), .pend_index_zero(pend_index_zero), .pend_access(pend_access),
        .log_push(log_push), .log_code(log_code));

    txsc_bc_model bc (.clk(clk), .cmd_start(cmd_start), .cmd_tr(cmd_tr), .cmd_sa(cmd_sa),
        .cmd_broadcast_received_flag(cmd_broadcast_received_flag), .msg_done(msg_done), .msg_error(msg_error), .msg_illegal(msg_illegal),
        .count_reached_zero(czero));

    // ---------------------------------------------------------------
    // host access and message tasks
    // ---------------------------------------------------------------
    task automatic wr(input logic [15:0] d);
        @(negedge clk);
        host_wr    = 1'b1;
        host_wdata = d;
        @(negedge clk);
        host_wr    = 1'b0;
    endtask : wr

    // read data is registered, so it is looked at one cycle after the strobe
    task automatic rd(input logic [15:0] exp);
        @(negedge clk);
        host_rd = 1'b1;
        @(negedge clk);
        host_rd = 1'b0;
        `TXSC_CHK(host_rdata, exp)
    endtask : rd

    task automatic msg(input logic expb, input logic busy, input logic err, input logic zero);
        bc.start(1'b1, 5'h01, 1'b0);
        `TXSC_CHK(transmit_data_enable, ~busy)
        `TXSC_CHK(busy_reply, busy)
        `TXSC_CHK(use_pointer_b, expb)
        bc.finish(err, 1'b0, zero, 2);
        `TXSC_CHK(transmit_data_enable, 1'b0)
    endtask : msg

    task automatic done_one(input string name);
        $display("test %s finished, compares so far %0d", name, tests_run);
    endtask : done_one

    task automatic test_done;
        $display("compares %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        test_done();
    end

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        logic [4:0] bad_sa [4] = '{5'h00, 5'h1f, 5'h01, 5'h02};
        logic       bad_tr [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
        repeat (6) @(negedge clk);
        rst = 1'b0;
        rd(16'h0000);
        `TXSC_CHK(pingpong_acknowledge, 1'b0)
        wr(16'hffff);
        rd(16'hd0ff);
        for (int i = 0; i < 8; i++) begin
            wr({13'h0000, i[2:0]});
            `TXSC_CHK(buffer_mode, i[2] ? 2'b11 : i[1] ? 2'b10 : {1'b0, i[0]})
        end
        wr(16'h0004);
        done_one("access and mode");
        // ping-pong with acknowledge: pointer alternates A, B
        execute = 1'b1;
        repeat (3) @(negedge clk);
        `TXSC_CHK(pingpong_acknowledge, 1'b1)
        msg(1'b0, 1'b0, 1'b0, 1'b0);
        rd(16'h0d04);
        rd(16'h0504);
        msg(1'b1, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            bc.start(bad_tr[i], bad_sa[i], 1'b0);
            `TXSC_CHK(transmit_data_enable, 1'b0)
            bc.finish(1'b0, 1'b0, 1'b0, 0);
        end
        rd(16'h0904);
        done_one("pingpong");
        // forced busy: no data, pointer held
        wr(16'h1000);
        msg(1'b0, 1'b1, 1'b0, 1'b0);
        rd(16'h1904);
        done_one("busy");
        // both alerts on one completion, then acknowledged
        gixz = 1'b1;
        gacc = 1'b1;
        wr(16'hc000);
        msg(1'b0, 1'b0, 1'b0, 1'b1);
        `TXSC_CHK({interrupt_out, pend_index_zero, pend_access}, 3'b111)
        `TXSC_CHK({log_push, log_code}, 3'b111)
        @(negedge clk);
        alert_ack = 1'b1;
        @(negedge clk);
        alert_ack = 1'b0;
        `TXSC_CHK({interrupt_out, pend_index_zero, pend_access}, 3'b000)
        rd(16'hcd04);
        done_one("alerts");
        // pause request drops the acknowledge; same buffer, no toggle
        wr(16'h0008);
        repeat (2) @(negedge clk);
        `TXSC_CHK(pingpong_acknowledge, 1'b0)
        msg(1'b1, 1'b0, 1'b0, 1'b0);
        rd(16'h0c0c);
        wr(16'h0000);
        repeat (2) @(negedge clk);
        rd(16'h0504);
        done_one("pause");
        // illegal messages: suppression holds the pointer, otherwise it flips; broadcast noted
        suppress = 1'b1;
        bc.start(1'b1, 5'h01, 1'b1);
        bc.finish(1'b0, 1'b1, 1'b0, 2);
        rd(16'h0f04);
        suppress = 1'b0;
        bc.start(1'b1, 5'h01, 1'b0);
        bc.finish(1'b0, 1'b1, 1'b0, 2);
        rd(16'h0b04);
        done_one("illegal");
        // software reset keeps host bits, then an errored message keeps the pointer
        @(negedge clk);
        software_reset = 1'b1;
        @(negedge clk);
        software_reset = 1'b0;
        rd(16'h0104);
        // clock enable low: this busy write must not land
        ce = 1'b0;
        wr(16'h1000);
        ce = 1'b1;
        msg(1'b0, 1'b0, 1'b1, 1'b0);
        rd(16'h0904);
        done_one("software reset");
        // master reset mid-run, then a ping-pong word written with the pin low
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd(16'h0000);
        execute = 1'b0;
        pin = 1'b0;
        repeat (3) @(negedge clk);
        wr(16'h0004);
        execute = 1'b1;
        repeat (3) @(negedge clk);
        `TXSC_CHK(pingpong_acknowledge, 1'b0)
        msg(1'b0, 1'b0, 1'b0, 1'b0);
        msg(1'b0, 1'b0, 1'b0, 1'b0);
        rd(16'h0804);
        done_one("unarmed");
        test_done();
    end
endmodule : txsc_core_bench
